// file: src/supervision_timer.sv
// One-time enabled supervision timer with reset pulse output
//
// Strobed register access was decided locally.


`timescale 1ns/10ps
`default_nettype none

`include "supervision_timer_regs.svh"

module supervision_timer #(
    // Counter width; a narrower counter only shortens the interval
    parameter int TIMER_W      = `TIMER_WIDTH,

    // Reset pin pulse length in clocks, per machine cycle mode
    parameter int PULSE_SIX    = `PULSE_OSC_SIX_CLOCK,
    parameter int PULSE_TWELVE = `PULSE_OSC_TWELVE_CLK
) (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       srst,

    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,

    // Mode select: high selects twelve-clock mode
    input  wire logic       twelve_clock_mode,

    // Status and reset output
    output logic            armed,
    output logic            reset_pin_out,
    output logic            device_reset
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------

    // Counter must fit the count field and still overflow at all ones
    if (TIMER_W < 2 || TIMER_W > 16) begin : g_bad_width
        $error("supervision_timer: TIMER_W out of range");
    end

    // Pulse countdown is eight bits wide
    if (PULSE_SIX < 1 || PULSE_SIX > 255) begin : g_bad_six
        $error("supervision_timer: PULSE_SIX out of range");
    end

    if (PULSE_TWELVE < 1 || PULSE_TWELVE > 255) begin : g_bad_twelve
        $error("supervision_timer: PULSE_TWELVE out of range");
    end

    // ------------------------------------------------------------------
    // Constants at the widths of the fields they meet
    // ------------------------------------------------------------------

    localparam logic [TIMER_W-1:0] CNT_ZERO =
        TIMER_W'(`TIMER_RESET_VALUE);

    localparam logic [TIMER_W-1:0] CNT_ONE =
        TIMER_W'(1);

    // All ones, 3FFF at the default width
    localparam logic [TIMER_W-1:0] CNT_LAST =
        {TIMER_W{1'b1}};

    localparam logic [7:0] PULSE_LEN_SIX =
        8'(PULSE_SIX);

    localparam logic [7:0] PULSE_LEN_TWELVE =
        8'(PULSE_TWELVE);

    localparam logic [3:0] DIV_LAST_SIX =
        4'(`MACHINE_DIV_SIX - 1);

    localparam logic [3:0] DIV_LAST_TWELVE =
        4'(`MACHINE_DIV_TWELVE - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    typedef struct packed {
        supervision_timer_pkg::key_state_t key;
        logic                               armed;
        logic [TIMER_W-1:0]                 count;
        logic [3:0]                         div;
        logic [7:0]                         pulse;
        logic                               pin;
        logic                               dev_rst;
        logic [7:0]                         rdata;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // ------------------------------------------------------------------
    // Decodes shared by the next-state logic
    // ------------------------------------------------------------------

    logic       key_wr;
    logic       key_first;
    logic       key_second;
    logic       mc_tick;
    logic       overflow;
    logic [3:0] div_last;
    logic [7:0] pulse_len;

    // Writes to any other address are not ours
    assign key_wr     = wr && (addr == `SERVICE_KEY_OFFSET);

    assign key_first  = (wdata == `SERVICE_KEY_FIRST);

    assign key_second = (wdata == `SERVICE_KEY_SECOND);

    assign div_last   = twelve_clock_mode ? DIV_LAST_TWELVE
                                          : DIV_LAST_SIX;

    // Clock stands for the oscillator; machine cycle is a divided enable.
    // Greater-or-equal so a mode change mid-cycle cannot skip the wrap.
    assign mc_tick    = (st_r.div >= div_last);

    assign overflow   = st_r.armed && (st_r.count == CNT_LAST);

    assign pulse_len  = twelve_clock_mode ? PULSE_LEN_TWELVE
                                          : PULSE_LEN_SIX;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------

    always_comb begin
        st_nxt         = st_r;
        st_nxt.dev_rst = 1'b0;

        // Key register and counter never read back; rd needs no decode
        st_nxt.rdata   = `READ_DATA_RESET;

        // Machine cycle divider runs free from reset, restarting at zero on overflow
        if (mc_tick) begin
            st_nxt.div = 4'h0;
        end else begin
            st_nxt.div = st_r.div + 4'h1;
        end

        // Counting only while armed
        if (st_r.armed && mc_tick) begin
            st_nxt.count = st_r.count + CNT_ONE;
        end

        // Key sequence; nothing here can clear armed
        if (key_wr) begin
            case (st_r.key)
                supervision_timer_pkg::KEY_IDLE: begin
                    if (key_first) begin
                        st_nxt.key = supervision_timer_pkg::KEY_GOT_1ST;
                    end
                end
                supervision_timer_pkg::KEY_GOT_1ST: begin
                    if (key_second) begin
                        st_nxt.armed = 1'b1;
                        st_nxt.count = CNT_ZERO;
                        st_nxt.key   = supervision_timer_pkg::KEY_IDLE;
                    end else if (!key_first) begin
                        // Repeated first key keeps the half pair
                        st_nxt.key   = supervision_timer_pkg::KEY_IDLE;
                    end
                end
                default: begin
                    st_nxt.key = supervision_timer_pkg::KEY_IDLE;
                end
            endcase
        end

        // Pulse countdown keeps running while the device sits in reset
        if (st_r.pulse != 8'h00) begin
            st_nxt.pulse = st_r.pulse - 8'h01;
            st_nxt.pin   = (st_r.pulse != 8'h01);
        end

        // Overflow wins over a key write landing in the same cycle
        if (overflow) begin
            st_nxt.armed   = 1'b0;
            st_nxt.count   = CNT_ZERO;
            st_nxt.key     = supervision_timer_pkg::KEY_IDLE;
            st_nxt.div     = 4'h0;
            st_nxt.dev_rst = 1'b1;
            st_nxt.pin     = 1'b1;
            st_nxt.pulse   = pulse_len;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    always_ff @(posedge clock) begin
        if (srst) begin
            st_r.key     <= supervision_timer_pkg::KEY_IDLE;
            st_r.armed   <= 1'b0;
            st_r.count   <= CNT_ZERO;
            st_r.div     <= 4'h0;
            st_r.pulse   <= 8'h00;
            st_r.pin     <= 1'b0;
            st_r.dev_rst <= 1'b0;
            st_r.rdata   <= `READ_DATA_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flip-flop
    // ------------------------------------------------------------------

    assign rdata         = st_r.rdata;

    assign armed         = st_r.armed;

    assign reset_pin_out = st_r.pin;

    // Internal reset is one cycle; the block clears itself meanwhile
    assign device_reset  = st_r.dev_rst;

endmodule

`default_nettype wire

// file: src/supervision_timer_pkg.sv
// Types shared by the supervision timer
`default_nettype none

package supervision_timer_pkg;

    typedef enum logic [1:0] {
        KEY_IDLE    = 2'b00,
        KEY_GOT_1ST = 2'b01
    } key_state_t;

endpackage

`default_nettype wire

// file: src/supervision_timer_regs.svh
// Register offsets, key values and timing counts of the supervision timer
`ifndef SUPERVISION_TIMER_REGS_SVH
`define SUPERVISION_TIMER_REGS_SVH

`define SERVICE_KEY_OFFSET    8'hA6
`define SERVICE_KEY_FIRST     8'h1E
`define SERVICE_KEY_SECOND    8'hE1
`define TIMER_WIDTH           14
`define TIMER_RESET_VALUE     14'h0000
`define TIMER_OVERFLOW_VALUE  14'h3FFF
`define PULSE_OSC_SIX_CLOCK   98
`define PULSE_OSC_TWELVE_CLK  196
`define MACHINE_DIV_SIX       6
`define MACHINE_DIV_TWELVE    12
`define READ_DATA_RESET       8'h00

`endif

// file: tb/supervision_timer_chk.sv
// Port assertions for the supervision timer
`timescale 1ns/10ps
`default_nettype none

`include "supervision_timer_regs.svh"

module supervision_timer_chk #(
    parameter int PULSE_SIX    = `PULSE_OSC_SIX_CLOCK,
    parameter int PULSE_TWELVE = `PULSE_OSC_TWELVE_CLK
) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       srst,
    // Register port
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    // Mode and outputs
    input wire logic       twelve_clock_mode,
    input wire logic       armed,
    input wire logic       reset_pin_out,
    input wire logic       device_reset
);
    logic [7:0] high_r;
    logic       half_r;
    wire logic  key_wr  = wr && addr == `SERVICE_KEY_OFFSET;
    wire logic  key_two = key_wr && wdata == `SERVICE_KEY_SECOND;
    // Length of the current reset pin pulse
    always_ff @(posedge clock) begin
        high_r <= (srst || !reset_pin_out) ? 8'h00 : high_r + 8'h01;
    end
    // Last key write was the first half; idle cycles keep it, an internal reset clears it
    always_ff @(posedge clock) begin
        if (srst)
            half_r <= 1'b0;
        else if (key_wr)
            half_r <= (wdata == `SERVICE_KEY_FIRST);
        else if (device_reset)
            half_r <= 1'b0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    rd_zero_a: assert property (rd |=> rdata == `READ_DATA_RESET)
        else $error("read data not zero");
    arm_seq_a: assert property (key_two && half_r |=> armed)
        else $error("key pair did not arm");
    lone_key_a: assert property (key_two && !half_r && !armed
        |=> !armed) else $error("lone second key armed");
    stay_armed_a: assert property (armed |=> armed || device_reset)
        else $error("timer disarmed without overflow");
    fall_cause_a: assert property ($fell(armed) && !$past(srst)
        |-> device_reset) else $error("disarm without reset");
    pin_cause_a: assert property ($rose(reset_pin_out)
        |-> device_reset) else $error("pin pulse without overflow");
    ovf_pulse_a: assert property (device_reset |-> reset_pin_out)
        else $error("no pin pulse on overflow");
    reset_once_a: assert property (device_reset |=> !device_reset)
        else $error("internal reset longer than one cycle");
    pulse_len_a: assert property ($fell(reset_pin_out) && !$past(srst)
        |-> high_r == (twelve_clock_mode ? PULSE_TWELVE : PULSE_SIX))
        else $error("reset pin pulse length wrong");
endmodule
bind supervision_timer supervision_timer_chk #(
    .PULSE_SIX   (PULSE_SIX),
    .PULSE_TWELVE(PULSE_TWELVE)
) u_supervision_timer_chk (.*);
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the supervision timer
`timescale 1ns/10ps
`default_nettype none

`include "supervision_timer_regs.svh"

`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
    $display("ERROR %0t %h %h", $time, (a), (e)); end end

module testbench;
    // Narrow counter keeps both overflow runs short
    localparam int TW      = 6;
    localparam int CNT_MAX = (1 << TW) - 1;
    // About twice the expected run length
    localparam int LIMIT   = 7000;
    logic       clock = 1'b0;
    logic       srst = 1'b1;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic       twelve_clock_mode = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       armed;
    logic       reset_pin_out;
    logic       device_reset;
    int         err_total = 0;
    int         cmp_count = 0;
    int         cyc = 0;
    int         ovf_count = 0;
    int         ovf_before;
    int         n;
    supervision_timer #(.TIMER_W(TW)) u_supervision_timer (.*);
    always #2 clock = ~clock;
    always @(posedge clock) begin
        if (device_reset === 1'b1) ovf_count++;
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            report_and_stop();
        end
    end
    task automatic key(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
    endtask
    task automatic idle();
        @(posedge clock);
        wr <= 1'b0;
        @(posedge clock) #1;
    endtask
    task automatic service();
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_FIRST);
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_SECOND);
        idle();
    endtask
    task automatic run_to_overflow(input int d, input int len);
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_FIRST);
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_SECOND);
        @(posedge clock);
        wr <= 1'b0;
        n = 1;
        while (device_reset !== 1'b1 && n < 2 * CNT_MAX * d) begin
            @(posedge clock) #1;
            n++;
        end
        `CHK(n >= (CNT_MAX - 1) * d + 3 && n <= CNT_MAX * d + 2, 1'b1)
        `CHK(armed, 1'b0)
        for (n = 0; reset_pin_out === 1'b1 && n < 300; n++)
            @(posedge clock) #1;
        `CHK(n, len)
    endtask
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        rd <= 1'b1;
        addr <= `SERVICE_KEY_OFFSET;
        @(posedge clock);
        rd <= 1'b0;
        #1 `CHK(rdata, `READ_DATA_RESET)
        `CHK(armed, 1'b0)
        `CHK({reset_pin_out, device_reset}, 2'b00)
        $display("read test done");
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_SECOND);
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_FIRST);
        key(`SERVICE_KEY_OFFSET, 8'h55);
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_SECOND);
        idle();
        `CHK(armed, 1'b0)
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_FIRST);
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_FIRST);
        key(`SERVICE_KEY_OFFSET, `SERVICE_KEY_SECOND);
        idle();
        `CHK(armed, 1'b1)
        $display("arm test done");
        key(`SERVICE_KEY_OFFSET, 8'h00);
        idle();
        `CHK(armed, 1'b1)
        ovf_before = ovf_count;
        repeat (6) begin
            repeat (200) @(posedge clock);
            service();
        end
        `CHK(ovf_count, ovf_before)
        `CHK(armed, 1'b1)
        $display("service test done");
        @(posedge clock);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock) #1;
        `CHK(armed, 1'b0)
        repeat (500) @(posedge clock);
        `CHK(ovf_count, ovf_before)
        $display("reset test done");
        run_to_overflow(`MACHINE_DIV_SIX, `PULSE_OSC_SIX_CLOCK);
        $display("six-clock overflow test done");
        @(posedge clock);
        twelve_clock_mode <= 1'b1;
        run_to_overflow(`MACHINE_DIV_TWELVE, `PULSE_OSC_TWELVE_CLK);
        $display("twelve-clock overflow test done");
        report_and_stop();
    end
endmodule
`default_nettype wire
